/* rtl/srco_top.v */
// system reset sequencer, reset pin states and clock output control
`timescale 1ns/1ps
`include "srco_consts.vh"

// Overview of operation
// - reset plus halt starts total system reset
// - reset instruction drives reset pin 124 clocks
// - instruction reset: core kept, others reset
// - total reset floats bus, cs high, flag low
// - total reset: bus grant follows bus request
// - total reset: gpio inputs, watchdog open drain
// - total reset: port1 inputs, rts and txd high
// - total reset: port3 rts and spares high
// - clock output runs, baud gen1 is clk/3 in total reset
// - reset leaves system ram contents alone
// - peripheral reset bits reset that peripheral
// - clock output strength selectable or off
// - one clock feeds core, cp and bus timing
// - internal accesses still drive the bus
// - chip selects and ack for external masters
module srco_top
#(
    parameter GPIO_W = 16           // general-purpose pin count
)
(
    mclk,
    rst,
    reset_pin_n_in,
    halt_pin_n_in,
    reset_pin_n_out,
    reset_pin_oe_n,
    reset_instr,
    cmd_reset_bit,
    dma_reset_bit,
    timer1_mode_reg_reset_bit,
    timer2_mode_reg_reset_bit,
    drive_sel,
    bus_req_n,
    core_bus_oe,
    core_cs_n,
    core_int_access,
    core_gpio_dir,
    core_port1_oe,
    core_port1_rts_n,
    core_port1_txd,
    core_port3_request_to_send_n,
    core_spare1,
    core_spare3,
    core_bus_grant_n,
    ext_master_hit,
    total_reset,
    core_reset,
    comm_processor_reset,
    sib_reset,
    dma_reset,
    timer1_reset,
    timer2_reset,
    system_clock_output,
    system_clock_output_drive,
    baud_gen1_output,
    bus_oe,
    chip_select_outputs,
    internal_access_flag,
    bus_grant_n,
    gpio_dir,
    watchdog_output_pin_oe_n,
    serial_port1_pins_oe,
    port1_rts_n,
    port1_txd,
    port3_request_to_send,
    spare_output_one,
    spare_output_three,
    ext_dtack_n
);
    input  wire              mclk;                     // system clock, also drives the clock output
    input  wire              rst;                      // synchronous power-on reset
    input  wire              reset_pin_n_in;           // reset pin level as seen
    input  wire              halt_pin_n_in;            // halt pin level as seen
    output reg               reset_pin_n_out;          // reset pin drive level (always low when enabled)
    output reg               reset_pin_oe_n;           // low while this end drives the reset pin
    input  wire              reset_instr;              // one-cycle pulse: core ran the reset instruction
    input  wire              cmd_reset_bit;            // write of the cp command reset bit
    input  wire              dma_reset_bit;            // write of the dma mode reset bit
    input  wire              timer1_mode_reg_reset_bit;           // write of the timer1 mode reset bit
    input  wire              timer2_mode_reg_reset_bit;           // write of the timer2 mode reset bit
    input  wire [1:0]        drive_sel;                // clock control strength field
    input  wire              bus_req_n;                // bus request input
    input  wire              core_bus_oe;              // normal address/data/control enable
    input  wire [3:0]        core_cs_n;                // normal chip selects
    input  wire              core_int_access;          // normal internal access flag
    input  wire [GPIO_W-1:0] core_gpio_dir;            // normal gpio directions
    input  wire              core_port1_oe;            // normal port1 enable
    input  wire              core_port1_rts_n;         // normal port1 rts
    input  wire              core_port1_txd;           // normal port1 txd
    input  wire              core_port3_request_to_send_n;              // normal port3 rts
    input  wire              core_spare1;              // normal spare one
    input  wire              core_spare3;              // normal spare three
    input  wire              core_bus_grant_n;         // normal arbiter grant
    input  wire              ext_master_hit;           // external master hit a chip-select range
    output reg               total_reset;              // total system reset in progress
    output reg               core_reset;               // core reset (total only)
    output reg               comm_processor_reset;     // cp reset
    output reg               sib_reset;                // system integration reset
    output reg               dma_reset;                // dma reset
    output reg               timer1_reset;             // timer1 reset
    output reg               timer2_reset;             // timer2 reset
    output reg               system_clock_output;      // enable of the clock output driver
    output reg  [1:0]        system_clock_output_drive;               // strength to the pad
    output reg               baud_gen1_output;         // clk/3 during total reset
    output reg               bus_oe;                   // address/data/control enable
    output reg  [3:0]        chip_select_outputs;      // chip selects, active low
    output reg               internal_access_flag;     // internal access indicator
    output reg               bus_grant_n;              // bus grant output
    output reg  [GPIO_W-1:0] gpio_dir;                 // gpio directions, 1 = output
    output reg               watchdog_output_pin_oe_n; // watchdog open drain, enable held high (off)
    output reg               serial_port1_pins_oe;     // port1 pins other than rts/txd
    output reg               port1_rts_n;              // port1 rts
    output reg               port1_txd;                // port1 txd
    output reg               port3_request_to_send;    // port3 rts
    output reg               spare_output_one;         // spare one
    output reg               spare_output_three;       // spare three
    output reg               ext_dtack_n;              // ack for external master in cs range

    wire        reset_s_n;     // synchronised reset pin
    wire        halt_s_n;      // synchronised halt pin
    reg  [7:0]  sw_cnt_reg;    // reset instruction drive counter
    reg  [7:0]  sw_cnt_next;
    reg  [1:0]  div_reg;       // divide-by-three counter
    reg  [1:0]  div_next;
    reg         tot_next;
    wire        sw_active;
    wire        sw_next_active; // reset pin is driven after this edge

    // *****************************************************************
    // input synchronisers
    // *****************************************************************
    srco_sync u_sync_reset
    (
        .mclk (mclk),
        .rst  (rst),
        .din  (reset_pin_n_in),
        .dout (reset_s_n)
    );

    srco_sync u_sync_halt
    (
        .mclk (mclk),
        .rst  (rst),
        .din  (halt_pin_n_in),
        .dout (halt_s_n)
    );

    assign sw_active = (sw_cnt_reg != 8'h00);
    assign sw_next_active = (sw_cnt_next != 8'h00);

    // *****************************************************************
    // next-state logic
    // *****************************************************************
    // our own drive of the reset pin must not count as a total reset,
    // so the pin is only qualified while we are not driving it
    always @*
    begin
        tot_next = (!reset_s_n) && (!halt_s_n) && !sw_active;
        if (reset_instr && !total_reset)
            sw_cnt_next = `SRCO_SWRST_CLOCKS;
        else if (sw_active)
            sw_cnt_next = sw_cnt_reg - 8'h01;
        else
            sw_cnt_next = sw_cnt_reg;
        if (div_reg == `SRCO_CLKDIV_LAST)
            div_next = 2'd0;
        else
            div_next = div_reg + 2'd1;
    end

    // *****************************************************************
    // registered outputs
    // *****************************************************************
    // power-on reset behaves as a total reset; ram is never cleared
    // here since no reset reaches its storage
    always @(posedge mclk)
    begin
        if (rst)
        begin
            total_reset              <= 1'b1;
            sw_cnt_reg               <= 8'h00;
            div_reg                  <= 2'd0;
            reset_pin_n_out          <= 1'b0;
            reset_pin_oe_n           <= 1'b1;
            core_reset               <= 1'b1;
            comm_processor_reset     <= 1'b1;
            sib_reset                <= 1'b1;
            dma_reset                <= 1'b1;
            timer1_reset             <= 1'b1;
            timer2_reset             <= 1'b1;
            system_clock_output      <= 1'b1;
            system_clock_output_drive               <= `SRCO_DRV_FULL;
            baud_gen1_output         <= 1'b0;
            bus_oe                   <= 1'b0;
            chip_select_outputs      <= `SRCO_CS_IDLE;
            internal_access_flag     <= 1'b0;
            bus_grant_n              <= 1'b1;
            gpio_dir                 <= {GPIO_W{1'b0}};
            watchdog_output_pin_oe_n <= 1'b1;
            serial_port1_pins_oe     <= 1'b0;
            port1_rts_n              <= 1'b1;
            port1_txd                <= 1'b1;
            port3_request_to_send    <= 1'b1;
            spare_output_one         <= 1'b1;
            spare_output_three       <= 1'b1;
            ext_dtack_n              <= 1'b1;
        end
        else
        begin
            total_reset     <= tot_next;
            sw_cnt_reg      <= sw_cnt_next;
            div_reg         <= div_next;
            reset_pin_n_out <= 1'b0;
            reset_pin_oe_n  <= !sw_next_active;
            // instruction reset leaves the core running; the peripheral resets rise
            // with the pin drive and outlast it by one edge so they never drop first
            core_reset           <= tot_next;
            comm_processor_reset <= tot_next || sw_next_active || sw_active || cmd_reset_bit;
            sib_reset            <= tot_next || sw_next_active || sw_active;
            dma_reset            <= tot_next || sw_next_active || sw_active || dma_reset_bit;
            timer1_reset         <= tot_next || sw_next_active || sw_active || timer1_mode_reg_reset_bit;
            timer2_reset         <= tot_next || sw_next_active || sw_active || timer2_mode_reg_reset_bit;
            // the clock keeps running through reset; strength is a pad choice
            case (drive_sel)
                `SRCO_DRV_OFF:
                begin
                    system_clock_output <= 1'b0;
                    system_clock_output_drive          <= `SRCO_DRV_OFF;
                end
                default:
                begin
                    system_clock_output <= 1'b1;
                    system_clock_output_drive          <= drive_sel;
                end
            endcase
            // baud output limited to mclk/3 resolution: a 1/3 duty square
            baud_gen1_output <= tot_next && (div_next == 2'd0);
            if (tot_next)
            begin
                bus_oe                   <= 1'b0;
                chip_select_outputs      <= `SRCO_CS_IDLE;
                internal_access_flag     <= 1'b0;
                bus_grant_n              <= bus_req_n;
                gpio_dir                 <= `SRCO_GPIO_ALL_IN;
                watchdog_output_pin_oe_n <= 1'b1;
                serial_port1_pins_oe     <= 1'b0;
                port1_rts_n              <= 1'b1;
                port1_txd                <= 1'b1;
                port3_request_to_send    <= 1'b1;
                spare_output_one         <= 1'b1;
                spare_output_three       <= 1'b1;
                ext_dtack_n              <= 1'b1;
            end
            else
            begin
                // internal accesses still drive the shared bus
                bus_oe                   <= core_bus_oe;
                chip_select_outputs      <= core_cs_n;
                internal_access_flag     <= core_int_access;
                bus_grant_n              <= core_bus_grant_n;
                gpio_dir                 <= core_gpio_dir;
                watchdog_output_pin_oe_n <= 1'b1;
                serial_port1_pins_oe     <= core_port1_oe;
                port1_rts_n              <= core_port1_rts_n;
                port1_txd                <= core_port1_txd;
                port3_request_to_send    <= core_port3_request_to_send_n;
                spare_output_one         <= core_spare1;
                spare_output_three       <= core_spare3;
                ext_dtack_n              <= !ext_master_hit;
            end
        end
    end
endmodule // srco_top

/* shared/srco_consts.vh */
// constants for the system reset and clock-out block
`ifndef SRCO_CONSTS_VH
`define SRCO_CONSTS_VH

// *****************************************************************
// timing
// *****************************************************************
`define SRCO_SWRST_CLOCKS     8'd124   // reset pin driven out after the reset instruction
`define SRCO_TOTAL_MIN_CLOCKS 4'd10    // least hold of reset and halt after power-on
`define SRCO_CLKDIV_LAST      2'd2     // divide-by-three counter terminal value

// *****************************************************************
// clock control field encodings (drive strength of the clock output)
// *****************************************************************
`define SRCO_DRV_OFF          2'd0
`define SRCO_DRV_THIRD        2'd1
`define SRCO_DRV_TWO_THIRDS   2'd2
`define SRCO_DRV_FULL         2'd3

// *****************************************************************
// forced pin levels under total reset
// *****************************************************************
`define SRCO_CS_IDLE          4'hf     // chip selects high (inactive)
`define SRCO_GPIO_ALL_IN      16'h0000 // direction: zero means input

`endif

/* rtl/srco_sync.v */
// two-flop synchroniser for the active-low reset and halt inputs
`timescale 1ns/1ps

module srco_sync
(
    mclk,
    rst,
    din,
    dout
);
    input  wire mclk;   // system clock
    input  wire rst;    // synchronous reset
    input  wire din;    // asynchronous level
    output reg  dout;   // synchronised level

    reg         meta_reg; // first stage, read only by dout

    // *****************************************************************
    // synchroniser
    // *****************************************************************
    // idle level is high because the inputs are active low
    always @(posedge mclk)
    begin
        if (rst)
        begin
            meta_reg <= 1'b1;
            dout     <= 1'b1;
        end
        else
        begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule // srco_sync

/* testbench/srco_checker.sv */
// assertion checker for the reset sequencer and clock-out block
`timescale 1ns/1ps
module srco_checker
#(
    parameter GPIO_W = 16 // general-purpose pin count
)
(
    input wire              mclk, rst, reset_pin_n_in, halt_pin_n_in, reset_pin_oe_n, reset_instr,
    input wire              cmd_reset_bit, dma_reset_bit, timer1_mode_reg_reset_bit, timer2_mode_reg_reset_bit, bus_req_n,
    input wire              ext_master_hit, total_reset, core_reset, comm_processor_reset, sib_reset,
    input wire              dma_reset, timer1_reset, timer2_reset, system_clock_output, baud_gen1_output,
    input wire              bus_oe, internal_access_flag, bus_grant_n, serial_port1_pins_oe, port1_rts_n,
    input wire              port1_txd, port3_request_to_send, spare_output_one, spare_output_three, ext_dtack_n,
    input wire              watchdog_output_pin_oe_n,
    input wire [1:0]        drive_sel, system_clock_output_drive,
    input wire [3:0]        chip_select_outputs,
    input wire [GPIO_W-1:0] gpio_dir
);
    reg  [1:0] up_cnt;              // edges since reset release, stops at 3
    reg  [7:0] sw_cnt;              // cycles since the last accepted reset instruction
    wire       ok = (up_cnt == 2'd3); // synchronisers now hold real pin levels
    // sw_cnt parks at ff so an idle block never looks like a running count
    always @(posedge mclk)
    begin
        up_cnt <= rst ? 2'd0 : (ok ? up_cnt : up_cnt + 2'd1);
        if (rst)
            sw_cnt <= 8'hff;
        else if (reset_instr && !total_reset)
            sw_cnt <= 8'h01;
        else if (sw_cnt != 8'hff)
            sw_cnt <= sw_cnt + 8'h01;
    end
    a_total_entry: assert property (@(posedge mclk) disable iff (rst)
        ok && $past(!reset_pin_n_in && !halt_pin_n_in && reset_pin_oe_n, 3) |-> total_reset)
        else $error("total reset did not start three edges after reset and halt");
    a_total_exit: assert property (@(posedge mclk) disable iff (rst)
        ok && $past(halt_pin_n_in, 3) |-> !total_reset) else $error("total reset without halt");
    a_swrst_len: assert property (@(posedge mclk) disable iff (rst)
        (sw_cnt >= 8'd1 && sw_cnt <= 8'd124) == !reset_pin_oe_n) else $error("reset pin drive length wrong");
    a_peri_sw: assert property (@(posedge mclk) disable iff (rst) !reset_pin_oe_n && !total_reset |->
        comm_processor_reset && sib_reset && dma_reset && timer1_reset && timer2_reset && !core_reset)
        else $error("instruction reset affected the wrong blocks");
    a_bus_float: assert property (@(posedge mclk) disable iff (rst) total_reset |->
        !bus_oe && chip_select_outputs == 4'hf && !internal_access_flag) else $error("bus not floated");
    a_grant_follow: assert property (@(posedge mclk) disable iff (rst)
        ok && total_reset |-> bus_grant_n == $past(bus_req_n)) else $error("grant does not follow request");
    a_pins_forced: assert property (@(posedge mclk) disable iff (rst) total_reset |->
        gpio_dir == {GPIO_W{1'b0}} && !serial_port1_pins_oe && port1_rts_n && port1_txd && watchdog_output_pin_oe_n
        && port3_request_to_send && spare_output_one && spare_output_three) else $error("pin states not forced");
    a_baud_third: assert property (@(posedge mclk) disable iff (rst) total_reset && baud_gen1_output |=>
        !baud_gen1_output [*2] ##1 (baud_gen1_output || !total_reset)) else $error("baud output not clock/3");
    a_system_clock_output_drive: assert property (@(posedge mclk) disable iff (rst)
        ok && !total_reset && $past(!total_reset) |-> system_clock_output_drive == $past(drive_sel)
        && system_clock_output == ($past(drive_sel) != 2'd0)) else $error("clock output strength wrong");
    a_peri_bits: assert property (@(posedge mclk) disable iff (rst)
        ok && !total_reset && !reset_instr && reset_pin_oe_n && $past(!total_reset) ##1 !total_reset |->
        {core_reset, sib_reset, comm_processor_reset, dma_reset, timer1_reset, timer2_reset}
        == {2'b00, $past({cmd_reset_bit, dma_reset_bit, timer1_mode_reg_reset_bit, timer2_mode_reg_reset_bit})})
        else $error("peripheral reset bit reached the wrong block");
    a_dtack_ext: assert property (@(posedge mclk) disable iff (rst)
        ok && !total_reset ##1 !total_reset |-> ext_dtack_n == !$past(ext_master_hit))
        else $error("external master acknowledge wrong");
endmodule // srco_checker
bind srco_top srco_checker #(.GPIO_W(GPIO_W)) srco_checker_inst (.*);

/* testbench/srco_ext_reset.sv */
// model of the external reset circuit on the reset and halt pins
`timescale 1ns/1ps
module srco_ext_reset
(
    input  wire mclk,            // system clock
    input  wire req,             // bench asks for a total reset
    input  wire reset_pin_oe_n,  // low while the block drives the reset pin
    input  wire reset_pin_n_out, // block's drive level on the reset pin
    output wire reset_pin_n_in,  // resolved reset pin, pulled up
    output wire halt_pin_n_in    // resolved halt pin, pulled up
);
    reg  [3:0] hold_cnt = 4'h0;            // cycles left of a total reset request
    wire       drive = (hold_cnt != 4'h0); // pulls reset and halt low together
    // each request reloads the count, so both lines stay low ten clocks or more
    always @(posedge mclk)
    begin
        if (req)
            hold_cnt <= 4'ha;
        else if (drive)
            hold_cnt <= hold_cnt - 4'h1;
    end
    // halt is never left high while this circuit pulls reset
    assign halt_pin_n_in  = !drive;
    assign reset_pin_n_in = !(drive || (!reset_pin_oe_n && !reset_pin_n_out));
endmodule // srco_ext_reset

/* testbench/srco_top_tb.sv */
// self-checking testbench for the reset sequencer and clock-out block
`timescale 1ns/1ps
module srco_top_tb;
    reg         mclk, rst, reset_instr, ext_req, cmd_reset_bit, dma_reset_bit, timer1_mode_reg_reset_bit, timer2_mode_reg_reset_bit;
    reg         bus_req_n, core_bus_oe, core_int_access, core_port1_oe, core_port1_rts_n, core_port1_txd;
    reg         core_port3_request_to_send_n, core_spare1, core_spare3, core_bus_grant_n, ext_master_hit;
    reg  [1:0]  drive_sel;
    reg  [3:0]  core_cs_n;
    reg  [15:0] core_gpio_dir;
    wire        reset_pin_n_in, halt_pin_n_in, reset_pin_n_out, reset_pin_oe_n, total_reset, core_reset;
    wire        comm_processor_reset, sib_reset, dma_reset, timer1_reset, timer2_reset, system_clock_output;
    wire        baud_gen1_output, bus_oe, internal_access_flag, bus_grant_n, watchdog_output_pin_oe_n;
    wire        serial_port1_pins_oe, port1_rts_n, port1_txd, port3_request_to_send, spare_output_one;
    wire        spare_output_three, ext_dtack_n;
    wire [1:0]  system_clock_output_drive;
    wire [3:0]  chip_select_outputs;
    wire [15:0] gpio_dir;
    integer     err_count = 0, check_count = 0, cyc = 0, n, i;
    srco_top srco_top_inst (.*);
    srco_ext_reset srco_ext_reset_inst (.mclk(mclk), .req(ext_req), .reset_pin_oe_n(reset_pin_oe_n),
        .reset_pin_n_out(reset_pin_n_out), .reset_pin_n_in(reset_pin_n_in), .halt_pin_n_in(halt_pin_n_in));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            err_count = err_count + 1;
            end_of_test;
        end
    end
    task chk(input [23:0] got, input [23:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    // inputs change on falling edges, outputs are read there one rising edge later
    initial
    begin
        {reset_instr, ext_req, cmd_reset_bit, dma_reset_bit, timer1_mode_reg_reset_bit, timer2_mode_reg_reset_bit, ext_master_hit} = 7'h00;
        {core_bus_oe, core_cs_n, core_int_access, core_port1_oe, core_port1_rts_n, core_port1_txd} = 9'h1ff;
        {core_port3_request_to_send_n, core_spare1, core_spare3, core_bus_grant_n, core_gpio_dir} = 20'hfffff;
        {rst, bus_req_n, drive_sel} = 4'hf;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        {core_bus_oe, core_cs_n, core_int_access, core_port1_oe, core_port1_rts_n, core_port1_txd} = 9'h15c;
        {core_port3_request_to_send_n, core_spare1, core_spare3, core_bus_grant_n, core_gpio_dir, ext_master_hit} = 21'h014b87;
        @(negedge mclk);
        chk({bus_oe, chip_select_outputs, internal_access_flag, serial_port1_pins_oe, port1_rts_n}, 8'hae);
        chk({port1_txd, port3_request_to_send, spare_output_one, spare_output_three, bus_grant_n}, 5'h00);
        chk({gpio_dir, ext_dtack_n}, 17'h14b86);
        ext_master_hit = 1'b0;
        @(negedge mclk);
        chk(ext_dtack_n, 1'b1);
        for (i = 0; i < 4; i = i + 1)
        begin
            drive_sel = i[1:0];
            {cmd_reset_bit, dma_reset_bit, timer1_mode_reg_reset_bit, timer2_mode_reg_reset_bit} = 4'h8 >> i;
            @(negedge mclk);
            chk({system_clock_output, system_clock_output_drive}, {i != 0, i[1:0]});
            chk({core_reset, sib_reset, comm_processor_reset, dma_reset, timer1_reset, timer2_reset}, 4'h8 >> i);
        end
        $display("test normal_mode done");
        {cmd_reset_bit, dma_reset_bit, timer1_mode_reg_reset_bit, timer2_mode_reg_reset_bit} = 4'h0;
        reset_instr = 1'b1;
        @(negedge mclk);
        reset_instr = 1'b0;
        chk({reset_pin_oe_n, reset_pin_n_in, core_reset, comm_processor_reset, sib_reset}, 5'h03);
        repeat (49) @(negedge mclk);
        reset_instr = 1'b1;
        @(negedge mclk);
        reset_instr = 1'b0;
        n = 0;
        while (reset_pin_oe_n === 1'b0 && n < 300)
        begin
            @(negedge mclk);
            n = n + 1;
        end
        chk(n, 124);
        chk(total_reset, 1'b0);
        @(negedge mclk);
        chk({comm_processor_reset, sib_reset, dma_reset, timer1_reset, timer2_reset}, 5'h00);
        $display("test instruction_reset done");
        ext_req = 1'b1;
        n = 0;
        while (total_reset !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n = n + 1;
        end
        chk(n, 4);
        chk({chip_select_outputs, internal_access_flag, bus_oe, gpio_dir}, 22'h3c0000);
        chk({port1_rts_n, port1_txd, serial_port1_pins_oe, port3_request_to_send, spare_output_one}, 5'h1b);
        chk({spare_output_three, core_reset, watchdog_output_pin_oe_n}, 3'h7);
        n = 0;
        for (i = 0; i < 9; i = i + 1)
        begin
            bus_req_n = i[0];
            @(negedge mclk);
            n = n + baud_gen1_output;
            chk({bus_grant_n, system_clock_output}, {i[0], 1'b1});
        end
        chk(n, 3);
        ext_req = 1'b0;
        n = 0;
        while (total_reset !== 1'b0 && n < 30)
        begin
            @(negedge mclk);
            n = n + 1;
        end
        chk(n, 13);
        chk({bus_oe, chip_select_outputs}, 5'h15);
        $display("test total_reset done");
        end_of_test;
    end
endmodule // srco_top_tb
